// ===== hdl/pp_cycle.sv
`default_nettype none
module pp_cycle (
    input  wire logic                      clk_sys,
    input  wire logic                      nrst,
    input  wire logic                      reqValid,
    output logic                           reqReady,
    input  wire pp_pkg::pp_req_s           req,
    input  wire logic [pp_pkg::DATA_W-1:0] pdIn,
    output logic [pp_pkg::DATA_W-1:0]      pdOut,
    output logic [pp_pkg::DATA_W-1:0]      pdOe,
    output logic                           wrStrobe,
    output logic                           rdStrobe,
    output logic                           latchPulse,
    output logic                           active,
    output logic                           doneRead,
    output logic [pp_pkg::DATA_W-1:0]      doneData
);
    import pp_pkg::*;
    localparam int unsigned CW = $clog2(STROBE_CYC + LATCH_CYC + 1);

    pp_phase_e      phase;
    pp_phase_e      next_phase;
    logic [CW-1:0]  count;
    logic           isWrite;

    wire logic countDone = (count == '0);
    assign reqReady = (phase == PH_IDLE);
    assign active   = (phase != PH_IDLE);

    // phase walk: latch address, strobe, done
    always_comb begin
        next_phase = phase;
        unique case (phase)
            PH_IDLE:   if (reqValid) next_phase = PH_LATCH;
            PH_LATCH:  if (countDone) next_phase = PH_STROBE;
            PH_STROBE: if (countDone) next_phase = PH_DONE;
            PH_DONE:   next_phase = PH_IDLE;
            default:   next_phase = PH_IDLE;
        endcase
    end

    // strobes are flops so pads never glitch
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            phase      <= PH_IDLE;
            count      <= '0;
            isWrite    <= 1'b0;
            pdOut      <= '0;
            pdOe       <= '0;
            wrStrobe   <= 1'b0;
            rdStrobe   <= 1'b0;
            latchPulse <= 1'b0;
            doneRead   <= 1'b0;
            doneData   <= '0;
        end else begin
            phase      <= next_phase;
            doneRead   <= 1'b0;
            latchPulse <= (next_phase == PH_LATCH);
            wrStrobe   <= (next_phase == PH_STROBE) & isWrite;
            rdStrobe   <= (next_phase == PH_STROBE) & ~isWrite;
            if (phase == PH_IDLE && reqValid) begin
                isWrite <= req.isWrite;
                pdOut   <= req.word;
                pdOe    <= {DATA_W{req.isWrite}};
                wrStrobe <= 1'b0;
                rdStrobe <= 1'b0;
                count   <= CW'(LATCH_CYC - 1);
            end else if (phase == PH_LATCH && countDone) begin
                count <= CW'(STROBE_CYC - 1);
            end else if (!countDone) begin
                count <= count - 1'b1;
            end
            // sample read data at the strobe's last cycle
            if (phase == PH_STROBE && countDone && !isWrite) begin
                doneRead <= 1'b1;
                doneData <= pdIn;
            end
            if (phase == PH_DONE) pdOe <= '0;
        end
    end
endmodule
`default_nettype wire

// ===== hdl/pp_fifo.sv
`default_nettype none
module pp_fifo #(
    parameter int unsigned WIDTH = 17,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic                       clk_sys,
    input  wire logic                       nrst,
    input  wire logic                       inValid,
    output logic                            inReady,
    input  wire logic [WIDTH-1:0]           inData,
    output logic                            outValid,
    input  wire logic                       outReady,
    output logic [WIDTH-1:0]                outData,
    output logic [$clog2(DEPTH+1)-1:0]      level
);
    import pp_pkg::*;
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0]    wrIdx;
    logic [AW-1:0]    rdIdx;
    wire  logic       push = inValid & inReady;
    wire  logic       pop  = outValid & outReady;

    // honest flags straight from the level
    assign inReady  = (level != DEPTH[$clog2(DEPTH+1)-1:0]);
    assign outValid = (level != '0);
    assign outData  = store[rdIdx];

    // storage has no reset; only valid entries are ever read
    always_ff @(posedge clk_sys) begin
        if (push) begin
            store[wrIdx] <= inData;
        end
    end

    // wrap by compare so depth need not be a power of two
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wrIdx <= '0;
            rdIdx <= '0;
            level <= '0;
        end else begin
            if (push) wrIdx <= (wrIdx == AW'(DEPTH - 1)) ? '0 : wrIdx + 1'b1;
            if (pop)  rdIdx <= (rdIdx == AW'(DEPTH - 1)) ? '0 : rdIdx + 1'b1;
            level <= level + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
        end
    end
endmodule
`default_nettype wire

// ===== hdl/pp_pkg.sv
`default_nettype none
package pp_pkg;
    // bus timing at 40 MHz
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned STROBE_NS     = 100;
    localparam int unsigned LATCH_NS      = 25;
    // least times round up
    localparam int unsigned STROBE_CYC = (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned LATCH_CYC  = (LATCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // register byte offsets
    localparam logic [4:0] OFS_CTRL  = 5'h00;
    localparam logic [4:0] OFS_DATA  = 5'h04;
    localparam logic [4:0] OFS_PINEN = 5'h08;
    localparam logic [4:0] OFS_ADDR  = 5'h0C;
    localparam logic [4:0] OFS_STAT  = 5'h10;

    // control word fields
    localparam int unsigned CTRL_CSF_LO    = 6;
    localparam int unsigned CTRL_MASTER    = 9;
    localparam int unsigned CTRL_SIXTEEN_BIT_WIDTH_SELECT    = 10;
    localparam int unsigned CTRL_ADDRESS_DATA_MULTIPLEX_LO = 11;
    localparam int unsigned CTRL_DUAL_BUFFER_SELECT   = 17;
    localparam logic [31:0] CTRL_MASK      = 32'h0002_1EC0;

    // reset values
    localparam logic [31:0] RST_CTRL  = 32'h0000_0000;
    localparam logic [15:0] RST_DATA  = 16'h0000;
    localparam logic [15:0] RST_PINEN = 16'h0000;
    localparam logic [15:0] RST_ADDR  = 16'h0000;

    localparam int unsigned DATA_W     = 16;
    localparam int unsigned FIFO_DEPTH = 8;

    typedef struct packed {
        logic              isWrite;
        logic [DATA_W-1:0] word;
    } pp_req_s;

    typedef struct packed {
        logic [1:0] chip_select_function;
        logic [1:0] address_data_multiplex;
        logic       master;
        logic       sixteen_bit_width_select;
        logic       dual_buffer_select;
    } pp_cfg_s;

    typedef enum logic [3:0] {
        PH_IDLE   = 4'b0001,
        PH_LATCH  = 4'b0010,
        PH_STROBE = 4'b0100,
        PH_DONE   = 4'b1000
    } pp_phase_e;
endpackage
`default_nettype wire

// ===== hdl/pp_port.sv
`default_nettype none
module pp_port #(
    parameter int unsigned DEPTH = pp_pkg::FIFO_DEPTH
) (
    input  wire logic                      clk_sys,
    input  wire logic                      nrst,
    input  wire logic [4:0]                avs_address,
    input  wire logic                      avs_read,
    input  wire logic                      avs_write,
    input  wire logic [31:0]               avs_writedata,
    input  wire logic [3:0]                avs_byteenable,
    output logic [31:0]                    avs_readdata,
    output logic                           avs_waitrequest,
    output logic [15:0]                    padAddr,
    output logic [15:0]                    padPortOwn,
    input  wire logic [pp_pkg::DATA_W-1:0] pdIn,
    output logic [pp_pkg::DATA_W-1:0]      pdOut,
    output logic [pp_pkg::DATA_W-1:0]      pdOe,
    output logic                           wrStrobe,
    output logic                           rdStrobe,
    input  wire logic                      hostCs,
    input  wire logic                      hostWr
);
    import pp_pkg::*;
    localparam int unsigned LW = $clog2(DEPTH + 1);

    logic [31:0]       ctrlWord;
    logic [DATA_W-1:0] dataWord;
    logic [15:0]       pinEnable;
    logic [15:0]       addrWord;
    logic              ack;
    logic [31:0]       next_readdata;

    pp_cfg_s           cfg;
    pp_req_s           pushReq;
    pp_req_s           headReq;
    logic              fifoInReady;
    logic              fifoOutValid;
    logic              fifoOutReady;
    logic [LW-1:0]     fifoLevel;
    logic              latchPulse;
    logic              cycleActive;
    logic              doneRead;
    logic [DATA_W-1:0] doneData;

    // configuration view of the control word
    assign cfg = '{
        chip_select_function:     ctrlWord[CTRL_CSF_LO +: 2],
        address_data_multiplex:  ctrlWord[CTRL_ADDRESS_DATA_MULTIPLEX_LO +: 2],
        master:  ctrlWord[CTRL_MASTER],
        sixteen_bit_width_select:  ctrlWord[CTRL_SIXTEEN_BIT_WIDTH_SELECT],
        dual_buffer_select: ctrlWord[CTRL_DUAL_BUFFER_SELECT]
    };

    // address decode and trigger detection
    wire logic busReq   = avs_read | avs_write;
    wire logic selCtrl  = (avs_address == OFS_CTRL);
    wire logic selData  = (avs_address == OFS_DATA);
    wire logic selPinEn = (avs_address == OFS_PINEN);
    wire logic selAddr  = (avs_address == OFS_ADDR);
    wire logic selStat  = (avs_address == OFS_STAT);
    wire logic dataLive = selData & ~cfg.dual_buffer_select;
    wire logic msbLane  = cfg.sixteen_bit_width_select ? avs_byteenable[1] : avs_byteenable[0];
    wire logic trigger  = busReq & dataLive & cfg.master & msbLane;
    wire logic canAck   = ~trigger | fifoInReady;
    wire logic wrTake   = avs_write & ack;
    wire logic hostLoad = ~cfg.master & hostCs & hostWr;

    // byte-lane merge of the data register
    wire logic [DATA_W-1:0] mergedData = {
        avs_byteenable[1] ? avs_writedata[15:8] : dataWord[15:8],
        avs_byteenable[0] ? avs_writedata[7:0]  : dataWord[7:0]
    };

    // one wait state; a full queue holds the master off
    assign avs_waitrequest = busReq & ~ack;
    assign pushReq = '{
        isWrite: avs_write,
        word:    avs_write ? mergedData : dataWord
    };

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) ack <= 1'b0;
        else       ack <= busReq & ~ack & canAck;
    end

    // answer timing on the register bus
    // a request is never answered in the cycle it appears
    wait_first_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        busReq && !ack |-> avs_waitrequest)
        else $error("request answered without a wait state");
    // a full queue keeps a top-byte access waiting
    full_hold_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        busReq && trigger && !fifoInReady && !ack |=> !ack)
        else $error("top byte access answered into a full queue");

    // read mux; unmapped and dual-buffer data read as zero
    always_comb begin
        next_readdata = 32'h0000_0000;
        if (selCtrl)  next_readdata = ctrlWord & CTRL_MASK;
        if (dataLive) next_readdata = {16'h0000, dataWord};
        if (selPinEn) next_readdata = {16'h0000, pinEnable};
        if (selAddr)  next_readdata = {16'h0000, addrWord};
        if (selStat)  next_readdata = {{(31 - LW){1'b0}}, fifoLevel, cycleActive};
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst)                        avs_readdata <= 32'h0000_0000;
        else if (avs_read && !ack && canAck) avs_readdata <= next_readdata;
    end

    // read answers carry the selected register
    // dual-buffer mode hides the data register
    dual_read_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        avs_read && ack && selData && cfg.dual_buffer_select |-> avs_readdata == 32'h0000_0000)
        else $error("data register readable in dual buffer mode");
    // data reads return what the register held when taken
    data_read_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        avs_read && ack && dataLive |-> avs_readdata == {16'h0000, $past(dataWord)})
        else $error("data read not returning register contents");
    // pin enables read back in the low half
    pin_read_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        avs_read && ack && selPinEn |-> avs_readdata[15:0] == pinEnable)
        else $error("pin enable read back wrong");

    // software writes land at the edge the master sees waitrequest low
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            ctrlWord  <= RST_CTRL;
            pinEnable <= RST_PINEN;
            addrWord  <= RST_ADDR;
        end else if (wrTake) begin
            if (selCtrl)  ctrlWord  <= avs_writedata & CTRL_MASK;
            if (selPinEn) pinEnable <= avs_writedata[15:0];
            if (selAddr)  addrWord  <= avs_writedata[15:0];
        end
    end

    // software beats a finished read cycle, host write only in slave mode
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst)                    dataWord <= RST_DATA;
        else if (wrTake && dataLive)  dataWord <= mergedData;
        else if (hostLoad)            dataWord <= pdIn;
        else if (doneRead)            dataWord <= doneData;
    end

    // data register update priority
    // software lane merge lands at the answer edge
    data_write_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        wrTake && dataLive |=> dataWord == $past(mergedData))
        else $error("data write did not land");
    // a slave-mode host write loads the pins
    host_load_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        hostLoad && !(wrTake && dataLive) |=> dataWord == $past(pdIn))
        else $error("host write not loaded");
    // a finished read cycle refreshes the register
    read_fill_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        doneRead && !(wrTake && dataLive) && !hostLoad |=> dataWord == $past(doneData))
        else $error("read cycle data not stored");

    pp_fifo #(
        .WIDTH ($bits(pp_req_s)),
        .DEPTH (DEPTH)
    ) u_queue (
        .clk_sys  (clk_sys),
        .nrst     (nrst),
        .inValid  (trigger & ack),
        .inReady  (fifoInReady),
        .inData   (pushReq),
        .outValid (fifoOutValid),
        .outReady (fifoOutReady),
        .outData  (headReq),
        .level    (fifoLevel)
    );

    pp_cycle u_cycle (
        .clk_sys    (clk_sys),
        .nrst       (nrst),
        .reqValid   (fifoOutValid),
        .reqReady   (fifoOutReady),
        .req        (headReq),
        .pdIn       (pdIn),
        .pdOut      (pdOut),
        .pdOe       (pdOe),
        .wrStrobe   (wrStrobe),
        .rdStrobe   (rdStrobe),
        .latchPulse (latchPulse),
        .active     (cycleActive),
        .doneRead   (doneRead),
        .doneData   (doneData)
    );

    // strobes and drive enables on the data pins
    // only one strobe at a time
    one_strobe_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        !(wrStrobe && rdStrobe))
        else $error("write and read strobes together");
    // pins are driven for the whole write strobe
    write_drive_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        wrStrobe |-> pdOe == '1)
        else $error("write strobe without driven pins");
    // pins are released for a read strobe
    read_float_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        rdStrobe |-> pdOe == '0)
        else $error("read strobe with driven pins");

    // pad ownership follows the enables one for one
    assign padPortOwn = pinEnable;

    // top pads: csf 00 address, 01 address plus cs one, 1x both selects
    wire logic csOne = cycleActive & (cfg.chip_select_function != 2'b00);
    wire logic csTwo = cycleActive & cfg.chip_select_function[1];
    wire logic [1:0] topPads = {cfg.chip_select_function[1] ? csTwo : addrWord[15],
                                (cfg.chip_select_function != 2'b00) ? csOne : addrWord[14]};
    // bottom pads: multiplexed modes strobe both latches
    wire logic [1:0] lowPads = (cfg.address_data_multiplex == 2'b00) ? addrWord[1:0]
                                                      : {latchPulse, latchPulse};
    assign padAddr = {topPads, addrWord[13:2], lowPads};

    // pad functions follow enables and mode fields
    // top and bottom pad ownership
    edge_own_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        {padPortOwn[15:14], padPortOwn[1:0]} == {pinEnable[15:14], pinEnable[1:0]})
        else $error("edge pad ownership not following enables");
    // middle pads always carry the address
    mid_pads_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        padAddr[13:2] == addrWord[13:2])
        else $error("middle pads not carrying address");
    // cs two on pad 15 when the field's upper bit is set
    cs_two_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        cfg.chip_select_function[1] |-> padAddr[15] == cycleActive)
        else $error("chip select two not shown");
    // cs one on pad 14 for any nonzero field
    cs_one_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        cfg.chip_select_function != 2'b00 |-> padAddr[14] == cycleActive)
        else $error("chip select one not shown");
    // plain address on the bottom pads when not multiplexed
    low_addr_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        cfg.address_data_multiplex == 2'b00 |-> padAddr[1:0] == addrWord[1:0])
        else $error("bottom pads not carrying address");

    // further checks gathered here, apart from the logic they guard
    wait_ack_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        busReq && !trigger && !ack |=> !avs_waitrequest || !busReq)
        else $error("plain access not answered after one wait");

    write_push_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        avs_write && ack && trigger |=> fifoLevel != '0 || cycleActive)
        else $error("top byte write started no cycle");

    read_push_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        avs_read && ack && trigger && fifoLevel == '0 && !cycleActive
        |=> ##[1:2] cycleActive)
        else $error("top byte read started no cycle");

    low_byte_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        busReq && ack && cfg.sixteen_bit_width_select && avs_byteenable[1:0] == 2'b01
        && fifoLevel == '0 && !cycleActive |=> !cycleActive)
        else $error("low byte access started a cycle");

    dual_buf_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        avs_write && ack && selData && cfg.dual_buffer_select |=> $stable(dataWord))
        else $error("data register used in dual buffer mode");

    pin_upper_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        avs_read && ack && selPinEn |-> avs_readdata[31:16] == 16'h0000)
        else $error("pin enable upper half not zero");

    pad_own_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        wrTake && selPinEn |=> padPortOwn == $past(avs_writedata[15:0]))
        else $error("pad ownership not following enables");

    cs_mux_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        cfg.chip_select_function == 2'b00 |-> padAddr[15:14] == addrWord[15:14])
        else $error("top pads not carrying address");

    latch_mux_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        cfg.address_data_multiplex != 2'b00 |-> padAddr[1:0] == {2{latchPulse}})
        else $error("bottom pads not carrying latch strobes");

    // the queue grows only on a live top-byte access
    // anything but a trigger leaves the queue no longer
    no_push_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        ack && !trigger |=> fifoLevel <= $past(fifoLevel))
        else $error("queue grew without a trigger");
    // dual-buffer data accesses queue nothing
    dual_quiet_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        busReq && selData && cfg.dual_buffer_select |=> fifoLevel <= $past(fifoLevel))
        else $error("dual buffer access queued a cycle");
    // eight-bit width ignores the upper lane as a trigger
    narrow_lane_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        busReq && selData && !cfg.sixteen_bit_width_select && !avs_byteenable[0]
        |=> fifoLevel <= $past(fifoLevel))
        else $error("upper lane triggered in eight bit width");
    // unused control bits are never stored
    ctrl_clean_a: assert property (@(posedge clk_sys) disable iff (!nrst)
        (ctrlWord & ~CTRL_MASK) == 32'h0000_0000)
        else $error("unused control bits stored");
endmodule
`default_nettype wire

// ===== testbench/pp_periph_model.sv
`default_nettype none
module pp_periph_model (
    input  wire logic        clk_sys,
    input  wire logic        nrst,
    input  wire logic [15:0] pdOut,
    input  wire logic [15:0] pdOe,
    input  wire logic        wrStrobe,
    input  wire logic        rdStrobe,
    input  wire logic        hostDrive,
    input  wire logic [15:0] rdWord,
    output logic      [15:0] pdIn,
    output logic      [15:0] lastWr,
    output logic      [7:0]  wrCount,
    output logic      [7:0]  rdCount
);
    timeunit 1ns;
    timeprecision 100ps;
    logic wrPrev;
    logic rdPrev;
    // off-strobe and without host drive the pins show the inverse, so stale data can never pass for a match
    assign pdIn = (rdStrobe || hostDrive) ? rdWord : ~rdWord;
    // count strobes at their start; capture only a fully driven bus
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wrPrev  <= 1'b0;
            rdPrev  <= 1'b0;
            wrCount <= 8'h00;
            rdCount <= 8'h00;
            lastWr  <= 16'h0000;
        end else begin
            wrPrev <= wrStrobe;
            rdPrev <= rdStrobe;
            if (wrStrobe && !wrPrev) wrCount <= wrCount + 8'h01;
            if (rdStrobe && !rdPrev) rdCount <= rdCount + 8'h01;
            if (wrStrobe && pdOe == 16'hFFFF) lastWr <= pdOut;
        end
    end
endmodule
`default_nettype wire

// ===== testbench/pp_port_tb.sv
`default_nettype none
module pp_port_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import pp_pkg::*;
    logic        clk_sys, nrst, avs_read, avs_write, avs_waitrequest;
    logic [4:0]  avs_address;
    logic [31:0] avs_writedata, avs_readdata, q;
    logic [3:0]  avs_byteenable;
    logic [15:0] padAddr, padPortOwn, pdIn, pdOut, pdOe, lastWr, rdWord;
    logic        wrStrobe, rdStrobe, hostCs, hostWr, hostDrive;
    logic [7:0]  wrCount, rdCount;
    int          err_count, checked;
    logic [4:0]  ofs [5] = '{OFS_CTRL, OFS_DATA, OFS_PINEN, OFS_ADDR, 5'h14};
    logic [31:0] cv  [4] = '{32'h200, 32'h240, 32'h280, 32'hA00};
    logic [15:0] pv  [4] = '{16'hC003, 16'h8003, 16'h0003, 16'hC000};

    pp_port u_pp_port (.clk_sys(clk_sys), .nrst(nrst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .padAddr(padAddr), .padPortOwn(padPortOwn),
        .pdIn(pdIn), .pdOut(pdOut), .pdOe(pdOe), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe),
        .hostCs(hostCs), .hostWr(hostWr));
    pp_periph_model u_pp_periph_model (.clk_sys(clk_sys), .nrst(nrst), .pdOut(pdOut),
        .pdOe(pdOe), .wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .hostDrive(hostDrive),
        .rdWord(rdWord), .pdIn(pdIn), .lastWr(lastWr), .wrCount(wrCount), .rdCount(rdCount));

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    task automatic final_report;
        if (err_count == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // one bus access; held until waitrequest is sampled low
    task automatic acc(input logic w, input logic [4:0] a, input logic [31:0] d,
                       input logic [3:0] be);
        int n;
        @(posedge clk_sys);
        avs_address    <= a;
        avs_write      <= w;
        avs_read       <= ~w;
        avs_writedata  <= d;
        avs_byteenable <= be;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 500);
        if (n >= 500) err_count++;
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] be);
        acc(1'b1, a, d, be);
    endtask

    task automatic rd(input logic [4:0] a, input logic [3:0] be, input logic [31:0] exp);
        acc(1'b0, a, 32'h0, be);
        check(q, exp);
    endtask

    // poll status until queue empty and no cycle in flight
    task automatic drain;
        int n;
        for (n = 0; n < 100; n++) begin
            acc(1'b0, OFS_STAT, 32'h0, 4'hF);
            if (q === 32'h0) break;
        end
        check(q, 32'h0);
    endtask

    // hang guard, well beyond the few hundred cycles of the sequence
    initial begin
        repeat (20000) @(posedge clk_sys);
        err_count++;
        final_report;
    end

    initial begin
        nrst = 1'b0;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        avs_byteenable = 4'h0;
        hostCs = 1'b0;
        hostWr = 1'b0;
        hostDrive = 1'b0;
        rdWord = 16'hBEEF;
        err_count = 0;
        checked = 0;
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        // reset values, unmapped slot reads zero
        for (int i = 0; i < 5; i++) rd(ofs[i], 4'hF, 32'h0);
        // pin enables: upper half not stored
        wr(OFS_PINEN, 32'hFFFF_A5C3, 4'hF);
        rd(OFS_PINEN, 4'hF, 32'h0000_A5C3);
        check({16'h0, padPortOwn}, 32'h0000_A5C3);
        wr(OFS_PINEN, 32'h0000_FFFF, 4'hF);
        @(posedge clk_sys);
        check({16'h0, padPortOwn}, 32'h0000_FFFF);
        // chip-select and multiplex field pick what top and bottom pads carry
        wr(OFS_ADDR, 32'h0000_C003, 4'hF);
        for (int i = 0; i < 4; i++) begin
            wr(OFS_CTRL, cv[i], 4'hF);
            repeat (2) @(posedge clk_sys);
            check({16'h0, padAddr}, {16'h0, pv[i]});
        end
        // sixteen-bit master: top-byte write launches a cycle
        wr(OFS_CTRL, 32'h0000_0600, 4'hF);
        wr(OFS_DATA, 32'h0000_1234, 4'h3);
        drain;
        check({16'h0, lastWr}, 32'h1234);
        check({24'h0, wrCount}, 32'h1);
        // low byte only: register changes, bus stays quiet
        wr(OFS_DATA, 32'h0000_0056, 4'h1);
        drain;
        check({24'h0, wrCount}, 32'h1);
        rd(OFS_DATA, 4'h1, 32'h1256);
        check({24'h0, rdCount}, 32'h0);
        // top-byte read launches a read cycle; data shows on the next read
        rd(OFS_DATA, 4'h3, 32'h1256);
        drain;
        check({24'h0, rdCount}, 32'h1);
        rd(OFS_DATA, 4'h1, 32'hBEEF);
        // eight-bit width: only the low lane triggers
        wr(OFS_CTRL, 32'h0000_0200, 4'hF);
        wr(OFS_DATA, 32'h0000_0000, 4'h2);
        drain;
        check({24'h0, wrCount}, 32'h1);
        wr(OFS_DATA, 32'h0000_00A5, 4'h1);
        drain;
        check({24'h0, wrCount}, 32'h2);
        check({24'h0, lastWr[7:0]}, 32'hA5);
        // dual-buffer mode leaves the register out of play
        wr(OFS_CTRL, 32'h0002_0600, 4'hF);
        wr(OFS_DATA, 32'h0000_7777, 4'h3);
        rd(OFS_DATA, 4'h3, 32'h0);
        drain;
        check({24'h0, wrCount}, 32'h2);
        check({24'h0, rdCount}, 32'h1);
        // back-to-back writes overrun the queue; none may be lost
        wr(OFS_CTRL, 32'h0000_0600, 4'hF);
        for (int i = 0; i < 20; i++) wr(OFS_DATA, 32'h0100 + i, 4'h3);
        drain;
        check({24'h0, wrCount}, 32'd22);
        check({16'h0, lastWr}, 32'h0113);
        // slave mode: host write loads the pins into the register
        wr(OFS_CTRL, 32'h0, 4'hF);
        @(posedge clk_sys);
        rdWord <= 16'h5AC3;
        hostDrive <= 1'b1;
        hostCs <= 1'b1;
        hostWr <= 1'b1;
        @(posedge clk_sys);
        hostCs <= 1'b0;
        hostWr <= 1'b0;
        hostDrive <= 1'b0;
        rd(OFS_DATA, 4'h3, 32'h5AC3);
        final_report;
    end
endmodule
`default_nettype wire
